//--- hw/pfs_pkg.sv
// package for the pin function select mux: offsets, reset values, field layouts
package pfs_pkg;
  localparam logic [3:0] PFS_ADDR_UPPER_PORTA_FUNCTION_SELECT = 4'h0;
  localparam logic [3:0] PFS_ADDR_LOWER_PORTB_FUNCTION_SELECT = 4'h1;
  localparam logic [3:0] PFS_ADDR_UPPER_PORTB_FUNCTION_SELECT = 4'h2;
  localparam logic [3:0] PFS_ADDR_PERIPHERAL_INPUT_SOURCE_SELECT = 4'h3;
  localparam logic [3:0] PFS_ADDR_PA_DATA = 4'h4;
  localparam logic [3:0] PFS_ADDR_PA_DIR = 4'h5;
  localparam logic [3:0] PFS_ADDR_PB_DATA = 4'h6;
  localparam logic [3:0] PFS_ADDR_PB_DIR = 4'h7;
  localparam logic [3:0] PFS_ADDR_PA_WAKE = 4'h8;
  localparam logic [3:0] PFS_ADDR_CTRL = 4'h9;
  localparam logic [3:0] PFS_ADDR_PA_PINS = 4'ha;
  localparam logic [3:0] PFS_ADDR_PB_PINS = 4'hb;
  localparam logic [3:0] PFS_ADDR_BITOP = 4'hc;
  localparam logic [7:0] PFS_SEL_RST = 8'h00;
  localparam logic [7:0] PFS_PORT_RST = 8'hff;
  localparam logic [7:0] PFS_WAKE_RST = 8'h00;
  localparam logic [7:0] PFS_UPPER_PORTB_FUNCTION_SELECT_MASK = 8'h03;
  // field low bit positions inside each select register
  localparam int PFS_F_HI = 6;
  localparam int PFS_F_MH = 4;
  localparam int PFS_F_ML = 2;
  localparam int PFS_F_LO = 0;
  // ctrl register bits
  localparam int PFS_CTRL_SIM_EN = 0;
  localparam int PFS_CTRL_MASTER = 1;
  localparam int PFS_CTRL_SLEEP = 2;
  localparam int PFS_CTRL_REDUCED = 3;
  // bit-op word: [7] 1=set 0=clear, [4] port b, [2:0] bit, [3] 1=direction reg
  localparam int PFS_OP_SET = 7;
  localparam int PFS_OP_PORTB = 4;
  localparam int PFS_OP_DIR = 3;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } pfs_bus_s;

  // peripheral signals toward the pads
  typedef struct packed {
    logic sck_out;
    logic sdo_unused;
    logic periodic_timer_out;
    logic std_timer_out;
    logic amp0_out;
    logic amp1_out;
  } pfs_periph_s;

  // inputs delivered to peripherals
  typedef struct packed {
    logic periodic_timer_capture_in;
    logic std_timer_capture_in;
    logic std_timer_clock_in;
    logic periodic_timer_clock_in;
    logic serial_chip_select;
    logic sck_in;
    logic sdi;
    logic external_interrupt0;
  } pfs_pin_in_s;
endpackage

//--- hw/pfs_pin_function_select_mux.sv
// pin function select mux with port data, direction and port a wake-up
//
// Implementation choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
// Notes on behaviour
// - pa7 field: serial clock, analog1, gpio+captures
// - pa6 field: gpio, periodic out, sdi, vref
// - pa5 field: amp1 output at 01, else gpio
// - pa4 field: gpio+periodic_timer_clock_in, inverted stp, an0, amp0
// - pb3 field: gpio, sdi at 10, 01 reserved
// - pb2 field: serial clock at 10, gpio otherwise
// - pb1 field: gpio only, 01/10 reserved
// - pb0 field: gpio+external_interrupt0, scs, stp, amp0 aux
// - pb4 field: scs at 01, gpio otherwise
// - upper pb select bits 7..2 read zero
// - capture source from pa7 at code 01
// - chip select source pb0, pb4, pa1
// - serial clock source pa0, pb2, pa7
// - spi master enabled: pa0, pb2 (field 10), pa7 (field 01) drive clock
// - serial data source pa2, pa6, pb3
// - reduced variant: PFS_CTRL_REDUCED bit is stored but unused, every field stays writable
// - reset sets port data and direction ones
// - output before write drives high
// - bit set/clear does port read-modify-write
// - port a falling edge wakes when enabled
module pfs_pin_function_select_mux (
  input wire logic clk_sys,
  input wire logic rst,
  input wire pfs_pkg::pfs_bus_s bus,
  output logic [7:0] rdata,
  input wire pfs_pkg::pfs_periph_s periph,
  output pfs_pkg::pfs_pin_in_s pin_in,
  output logic [7:0] pa_out,
  output logic [7:0] pa_oe,
  input wire logic [7:0] pa_in,
  output logic [4:0] pb_out,
  output logic [4:0] pb_oe,
  input wire logic [4:0] pb_in,
  output logic [7:0] analog_en,
  output logic wake
);
  import pfs_pkg::*;

  logic [7:0] upper_porta_function_select_q, lower_portb_function_select_q, upper_portb_function_select_q, peripheral_input_source_select_q;
  logic [7:0] pa_data_q, pa_dir_q, pa_wake_q, ctrl_q;
  logic [4:0] pb_data_q, pb_dir_q;
  logic [7:0] pa_s1_q, pa_s2_q, pa_s3_q, pa_st_q;
  logic [4:0] pb_s1_q, pb_s2_q, pb_s3_q, pb_st_q;
  logic [7:0] rdata_q;
  logic wake_q;

  function automatic logic [1:0] fld(input logic [7:0] r, input int lo);
    fld = r[lo +: 2];
  endfunction

  // three-stage input sync; a change counts once stages two and three agree
  always_ff @(posedge clk_sys) begin
    pa_s1_q <= pa_in;
    pa_s2_q <= pa_s1_q;
    pa_s3_q <= pa_s2_q;
    pb_s1_q <= pb_in;
    pb_s2_q <= pb_s1_q;
    pb_s3_q <= pb_s2_q;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pa_st_q <= PFS_PORT_RST;
      pb_st_q <= PFS_PORT_RST[4:0];
    end else begin
      pa_st_q <= (pa_s2_q & pa_s3_q) | (pa_st_q & (pa_s2_q | pa_s3_q));
      pb_st_q <= (pb_s2_q & pb_s3_q) | (pb_st_q & (pb_s2_q | pb_s3_q));
    end
  end

  // bit-op: whole port read, one bit changed, whole port written back
  logic [7:0] bit_mask;
  logic [7:0] pa_rmw, pb_rmw;
  always_comb begin
    bit_mask = 8'h01 << bus.wdata[2:0];
    pa_rmw = pa_dir_q;
    pb_rmw = {3'h0, pb_dir_q};
    if (!bus.wdata[PFS_OP_DIR]) begin
      // data bits read back from the pins, as a real port does
      pa_rmw = pa_st_q;
      pb_rmw = {3'h0, pb_st_q};
    end
    pa_rmw = bus.wdata[PFS_OP_SET] ? (pa_rmw | bit_mask) : (pa_rmw & ~bit_mask);
    pb_rmw = bus.wdata[PFS_OP_SET] ? (pb_rmw | bit_mask) : (pb_rmw & ~bit_mask);
  end

  logic bitop_pa_data, bitop_pa_dir, bitop_pb_data, bitop_pb_dir;
  assign bitop_pa_data = bus.wr && bus.addr == PFS_ADDR_BITOP && !bus.wdata[PFS_OP_PORTB] && !bus.wdata[PFS_OP_DIR];
  assign bitop_pa_dir = bus.wr && bus.addr == PFS_ADDR_BITOP && !bus.wdata[PFS_OP_PORTB] && bus.wdata[PFS_OP_DIR];
  assign bitop_pb_data = bus.wr && bus.addr == PFS_ADDR_BITOP && bus.wdata[PFS_OP_PORTB] && !bus.wdata[PFS_OP_DIR];
  assign bitop_pb_dir = bus.wr && bus.addr == PFS_ADDR_BITOP && bus.wdata[PFS_OP_PORTB] && bus.wdata[PFS_OP_DIR];

  // select registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      upper_porta_function_select_q <= PFS_SEL_RST;
      lower_portb_function_select_q <= PFS_SEL_RST;
      upper_portb_function_select_q <= PFS_SEL_RST;
      peripheral_input_source_select_q <= PFS_SEL_RST;
      ctrl_q <= PFS_SEL_RST;
    end else if (bus.wr) begin
      unique case (bus.addr)
        PFS_ADDR_UPPER_PORTA_FUNCTION_SELECT: upper_porta_function_select_q <= bus.wdata;
        PFS_ADDR_LOWER_PORTB_FUNCTION_SELECT: lower_portb_function_select_q <= bus.wdata;
        PFS_ADDR_UPPER_PORTB_FUNCTION_SELECT: upper_portb_function_select_q <= bus.wdata & PFS_UPPER_PORTB_FUNCTION_SELECT_MASK;
        PFS_ADDR_PERIPHERAL_INPUT_SOURCE_SELECT: peripheral_input_source_select_q <= bus.wdata;
        PFS_ADDR_CTRL: ctrl_q <= bus.wdata;
        default: ;
      endcase
    end
  end

  // port data and direction
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pa_data_q <= PFS_PORT_RST;
      pa_dir_q <= PFS_PORT_RST;
      pb_data_q <= PFS_PORT_RST[4:0];
      pb_dir_q <= PFS_PORT_RST[4:0];
      pa_wake_q <= PFS_WAKE_RST;
    end else begin
      if (bus.wr && bus.addr == PFS_ADDR_PA_DATA) pa_data_q <= bus.wdata;
      else if (bitop_pa_data) pa_data_q <= pa_rmw;
      if (bus.wr && bus.addr == PFS_ADDR_PA_DIR) pa_dir_q <= bus.wdata;
      else if (bitop_pa_dir) pa_dir_q <= pa_rmw;
      if (bus.wr && bus.addr == PFS_ADDR_PB_DATA) pb_data_q <= bus.wdata[4:0];
      else if (bitop_pb_data) pb_data_q <= pb_rmw[4:0];
      if (bus.wr && bus.addr == PFS_ADDR_PB_DIR) pb_dir_q <= bus.wdata[4:0];
      else if (bitop_pb_dir) pb_dir_q <= pb_rmw[4:0];
      if (bus.wr && bus.addr == PFS_ADDR_PA_WAKE) pa_wake_q <= bus.wdata;
    end
  end

  // read port, data in the cycle after the strobe
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rdata_q <= 8'h00;
    end else if (bus.rd) begin
      unique case (bus.addr)
        PFS_ADDR_UPPER_PORTA_FUNCTION_SELECT: rdata_q <= upper_porta_function_select_q;
        PFS_ADDR_LOWER_PORTB_FUNCTION_SELECT: rdata_q <= lower_portb_function_select_q;
        PFS_ADDR_UPPER_PORTB_FUNCTION_SELECT: rdata_q <= upper_portb_function_select_q & PFS_UPPER_PORTB_FUNCTION_SELECT_MASK;
        PFS_ADDR_PERIPHERAL_INPUT_SOURCE_SELECT: rdata_q <= peripheral_input_source_select_q;
        PFS_ADDR_PA_DATA: rdata_q <= pa_data_q;
        PFS_ADDR_PA_DIR: rdata_q <= pa_dir_q;
        PFS_ADDR_PB_DATA: rdata_q <= {3'h0, pb_data_q};
        PFS_ADDR_PB_DIR: rdata_q <= {3'h0, pb_dir_q};
        PFS_ADDR_PA_WAKE: rdata_q <= pa_wake_q;
        PFS_ADDR_CTRL: rdata_q <= ctrl_q;
        PFS_ADDR_PA_PINS: rdata_q <= pa_st_q;
        PFS_ADDR_PB_PINS: rdata_q <= {3'h0, pb_st_q};
        default: rdata_q <= 8'h00;
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end
  assign rdata = rdata_q;

  // pad output muxes
  logic [1:0] f_pa7, f_pa6, f_pa5, f_pa4, f_pb3, f_pb2, f_pb1, f_pb0, f_pb4;
  logic spi_master_clk;
  logic [7:0] pa_func, pa_fval;
  logic [4:0] pb_func, pb_fval;
  always_comb begin
    f_pa7 = fld(upper_porta_function_select_q, PFS_F_HI);
    f_pa6 = fld(upper_porta_function_select_q, PFS_F_MH);
    f_pa5 = fld(upper_porta_function_select_q, PFS_F_ML);
    f_pa4 = fld(upper_porta_function_select_q, PFS_F_LO);
    f_pb3 = fld(lower_portb_function_select_q, PFS_F_HI);
    f_pb2 = fld(lower_portb_function_select_q, PFS_F_MH);
    f_pb1 = fld(lower_portb_function_select_q, PFS_F_ML);
    f_pb0 = fld(lower_portb_function_select_q, PFS_F_LO);
    f_pb4 = fld(upper_portb_function_select_q, PFS_F_LO);
    spi_master_clk = ctrl_q[PFS_CTRL_SIM_EN] && ctrl_q[PFS_CTRL_MASTER];
    pa_func = 8'h00;
    pa_fval = 8'h00;
    pb_func = 5'h00;
    pb_fval = 5'h00;
    analog_en = 8'h00;
    // pa7
    if (f_pa7 == 2'b01) begin
      pa_func[7] = spi_master_clk;
      pa_fval[7] = periph.sck_out;
    end
    analog_en[1] = f_pa7 == 2'b10;
    // pa6
    if (f_pa6 == 2'b01) begin
      pa_func[6] = 1'b1;
      pa_fval[6] = periph.periodic_timer_out;
    end
    analog_en[2] = f_pa6 == 2'b11;
    // pa5
    if (f_pa5 == 2'b01) begin
      pa_func[5] = 1'b1;
      pa_fval[5] = periph.amp1_out;
    end
    // pa4
    unique case (f_pa4)
      2'b01: begin
        pa_func[4] = 1'b1;
        pa_fval[4] = ~periph.std_timer_out;
      end
      2'b11: begin
        pa_func[4] = 1'b1;
        pa_fval[4] = periph.amp0_out;
      end
      default: ;
    endcase
    analog_en[0] = f_pa4 == 2'b10;
    // pa0 clock out in spi master, regardless of source field
    pa_func[0] = spi_master_clk;
    pa_fval[0] = periph.sck_out;
    // pb2
    pb_func[2] = spi_master_clk && (f_pb2 == 2'b10);
    pb_fval[2] = periph.sck_out;
    // pb0
    if (f_pb0 == 2'b10) begin
      pb_func[0] = 1'b1;
      pb_fval[0] = periph.std_timer_out;
    end
    analog_en[3] = f_pb0 == 2'b11;
    // pb3, pb1, pb4 carry only inputs or gpio on the output side
    analog_en[7:4] = 4'h0;
  end

  // direction bit one means input, so oe is its inverse unless a peripheral output drives the pad
  assign pa_oe = pa_func | ~pa_dir_q;
  assign pa_out = (pa_func & pa_fval) | (~pa_func & pa_data_q);
  assign pb_oe = pb_func | ~pb_dir_q;
  assign pb_out = (pb_func & pb_fval) | (~pb_func & pb_data_q);

  // input source muxes: only the chosen pad reaches the peripheral
  always_comb begin
    pin_in = '0;
    pin_in.periodic_timer_capture_in = (fld(peripheral_input_source_select_q, PFS_F_HI) == 2'b01) && (f_pa7 == 2'b11) && pa_st_q[7];
    pin_in.std_timer_capture_in = (f_pa7 == 2'b11) && pa_st_q[7];
    pin_in.std_timer_clock_in = (f_pa5 != 2'b01) && pa_st_q[5];
    pin_in.periodic_timer_clock_in = (f_pa4 == 2'b00) && pa_st_q[4];
    pin_in.external_interrupt0 = (f_pb0 == 2'b00) && pb_st_q[0];
    unique case (fld(peripheral_input_source_select_q, PFS_F_MH))
      2'b01: pin_in.serial_chip_select = (f_pb4 == 2'b01) ? pb_st_q[4] : 1'b1;
      2'b10: pin_in.serial_chip_select = pa_st_q[1];
      default: pin_in.serial_chip_select = (f_pb0 == 2'b01) ? pb_st_q[0] : 1'b1;
    endcase
    unique case (fld(peripheral_input_source_select_q, PFS_F_ML))
      2'b00: pin_in.sck_in = pa_st_q[0];
      2'b10: pin_in.sck_in = (f_pa7 == 2'b01) && pa_st_q[7];
      default: pin_in.sck_in = (f_pb2 == 2'b10) && pb_st_q[2];
    endcase
    unique case (fld(peripheral_input_source_select_q, PFS_F_LO))
      2'b01: pin_in.sdi = (f_pa6 == 2'b10) && pa_st_q[6];
      2'b10: pin_in.sdi = (f_pb3 == 2'b10) && pb_st_q[3];
      default: pin_in.sdi = pa_st_q[2];
    endcase
  end

  // wake on falling edge of an enabled port a pin while asleep
  logic [7:0] pa_prev_q;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pa_prev_q <= PFS_PORT_RST;
      wake_q <= 1'b0;
    end else begin
      pa_prev_q <= pa_st_q;
      wake_q <= ctrl_q[PFS_CTRL_SLEEP] && |(pa_wake_q & pa_prev_q & ~pa_st_q);
    end
  end
  assign wake = wake_q;

  a_upper_portb_function_select_upper_zero: assert property (@(posedge clk_sys) disable iff (rst)
    bus.rd && bus.addr == PFS_ADDR_UPPER_PORTB_FUNCTION_SELECT |=> rdata[7:2] == 6'h00)
    else $error("upper pb select high bits not zero");
  a_reset_ports_ones: assert property (@(posedge clk_sys)
    $past(rst) |-> pa_dir_q == 8'hff && pa_data_q == 8'hff && pb_dir_q == 5'h1f)
    else $error("port regs not all ones after reset");
  a_first_out_high: assert property (@(posedge clk_sys) disable iff (rst)
    !pa_func[3] && !pa_dir_q[3] && pa_data_q[3] |-> pa_out[3] && pa_oe[3])
    else $error("gpio output not driving data");
  a_wake_edge: assert property (@(posedge clk_sys) disable iff (rst)
    ctrl_q[PFS_CTRL_SLEEP] && pa_wake_q[0] && pa_st_q[0] ##1 !pa_st_q[0] && $stable(ctrl_q) ##1 1'b1
    |-> wake)
    else $error("falling edge did not wake");
  a_periodic_timer_capture_in_gated: assert property (@(posedge clk_sys) disable iff (rst)
    fld(peripheral_input_source_select_q, PFS_F_HI) != 2'b01 |-> !pin_in.periodic_timer_capture_in)
    else $error("capture input leaked without 01 source");
  a_scs_pa1: assert property (@(posedge clk_sys) disable iff (rst)
    fld(peripheral_input_source_select_q, PFS_F_MH) == 2'b10 |-> pin_in.serial_chip_select == pa_st_q[1])
    else $error("chip select not from pa1");
  a_sck_pa0: assert property (@(posedge clk_sys) disable iff (rst)
    fld(peripheral_input_source_select_q, PFS_F_ML) == 2'b00 |-> pin_in.sck_in == pa_st_q[0])
    else $error("serial clock not from pa0");
  a_spi_clk_out: assert property (@(posedge clk_sys) disable iff (rst)
    spi_master_clk |-> pa_oe[0] && pa_out[0] == periph.sck_out)
    else $error("pa0 not clock out in master");
  a_sdi_pb3: assert property (@(posedge clk_sys) disable iff (rst)
    fld(peripheral_input_source_select_q, PFS_F_LO) == 2'b10 && f_pb3 != 2'b10 |-> !pin_in.sdi)
    else $error("sdi leaked from unselected pb3");
  a_amp1_pa5: assert property (@(posedge clk_sys) disable iff (rst)
    f_pa5 == 2'b01 |-> pa_out[5] == periph.amp1_out)
    else $error("pa5 amp1 output missing");
  a_rmw_set: assert property (@(posedge clk_sys) disable iff (rst)
    bitop_pa_dir && bus.wdata[PFS_OP_SET] |=> pa_dir_q == ($past(pa_dir_q) | $past(bit_mask)))
    else $error("bit set did not rmw direction");
  c_wake: cover property (@(posedge clk_sys) wake);
  c_spi_master: cover property (@(posedge clk_sys) spi_master_clk);
  c_rmw_clear: cover property (@(posedge clk_sys) bitop_pa_data && !bus.wdata[PFS_OP_SET]);
  c_scs_pb4: cover property (@(posedge clk_sys) fld(peripheral_input_source_select_q, PFS_F_MH) == 2'b01 && f_pb4 == 2'b01);
endmodule // pfs_pin_function_select_mux

//--- tb/pfs_pad_model.sv
// pad-side model: external drivers resolved against the block's own pad drive
`timescale 1ns/1ps
module pfs_pad_model (
  input wire logic [7:0] pa_out,
  input wire logic [7:0] pa_oe,
  input wire logic [4:0] pb_out,
  input wire logic [4:0] pb_oe,
  input wire logic [7:0] ext_pa,
  input wire logic [4:0] ext_pb,
  output logic [7:0] pa_in,
  output logic [4:0] pb_in
);
  // external source is strong but the block wins where it drives, so readback shows real pin state
  assign pa_in = (pa_oe & pa_out) | (~pa_oe & ext_pa);
  assign pb_in = (pb_oe & pb_out) | (~pb_oe & ext_pb);
endmodule // pfs_pad_model

//--- tb/pfs_pin_function_select_mux_test.sv
// self-checking bench for the pin function select mux
`timescale 1ns/1ps
module pfs_pin_function_select_mux_test;
  import pfs_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  pfs_bus_s bus = '0;
  pfs_periph_s periph = '0;
  pfs_pin_in_s pin_in;
  logic [7:0] rdata, pa_out, pa_oe, pa_in, analog_en;
  logic [7:0] ext_pa = 8'h00;
  logic [4:0] pb_out, pb_oe, pb_in;
  logic [4:0] ext_pb = 5'h00;
  logic wake;
  int error_cnt = 0;
  int num_checks = 0;

  always #2 clk_sys = ~clk_sys;

  pfs_pin_function_select_mux i_dut (.clk_sys(clk_sys), .rst(rst), .bus(bus), .rdata(rdata), .periph(periph),
    .pin_in(pin_in), .pa_out(pa_out), .pa_oe(pa_oe), .pa_in(pa_in), .pb_out(pb_out), .pb_oe(pb_oe),
    .pb_in(pb_in), .analog_en(analog_en), .wake(wake));
  pfs_pad_model i_pads (.pa_out(pa_out), .pa_oe(pa_oe), .pb_out(pb_out), .pb_oe(pb_oe), .ext_pa(ext_pa),
    .ext_pb(ext_pb), .pa_in(pa_in), .pb_in(pb_in));

  task automatic close_out;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic fail(input string msg);
    error_cnt++;
    $display("mismatch at %0t: %s", $time, msg);
  endtask

  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp, input string msg);
    num_checks++;
    if (got !== exp) fail($sformatf("%s got %h exp %h", msg, got, exp));
  endtask

  task automatic chk_pin(input logic got, input logic exp, input string msg);
    num_checks++;
    if (got !== exp) fail(msg);
  endtask

  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    bus.wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic reg_chk(input logic [3:0] a, input logic [7:0] exp, input string msg);
    @(posedge clk_sys);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    bus.rd <= 1'b0;
    #1 chk_reg(rdata, exp, msg);
  endtask

  task automatic settle;
    @(posedge clk_sys);
    #1;
  endtask

  // pad changes need the input synchroniser to pass before they show
  task automatic pads(input logic [7:0] a, input logic [4:0] b);
    @(posedge clk_sys);
    ext_pa <= a;
    ext_pb <= b;
    repeat (6) @(posedge clk_sys);
    #1;
  endtask

  task automatic t_reset;
    reg_chk(PFS_ADDR_UPPER_PORTA_FUNCTION_SELECT, 8'h00, "upper_porta_function_select reset");
    reg_chk(PFS_ADDR_LOWER_PORTB_FUNCTION_SELECT, 8'h00, "lower_portb_function_select reset");
    reg_chk(PFS_ADDR_UPPER_PORTB_FUNCTION_SELECT, 8'h00, "upper_portb_function_select reset");
    reg_chk(PFS_ADDR_PERIPHERAL_INPUT_SOURCE_SELECT, 8'h00, "peripheral_input_source_select reset");
    reg_chk(PFS_ADDR_PA_DATA, 8'hff, "pa data reset");
    reg_chk(PFS_ADDR_PA_DIR, 8'hff, "pa dir reset");
    reg_chk(PFS_ADDR_PB_DATA, 8'h1f, "pb data reset");
    reg_chk(PFS_ADDR_PB_DIR, 8'h1f, "pb dir reset");
    chk_reg(pa_oe, 8'h00, "pa driven after reset");
    chk_reg({3'h0, pb_oe}, 8'h00, "pb driven after reset");
    reg_wr(PFS_ADDR_UPPER_PORTB_FUNCTION_SELECT, 8'hff);
    reg_chk(PFS_ADDR_UPPER_PORTB_FUNCTION_SELECT, 8'h03, "upper_portb_function_select unused bits");
    reg_wr(4'hd, 8'h5a);
    reg_chk(4'hd, 8'h00, "unmapped read");
  endtask

  task automatic t_out_high;
    reg_wr(PFS_ADDR_UPPER_PORTB_FUNCTION_SELECT, 8'h00);
    reg_wr(PFS_ADDR_PA_DIR, 8'h00);
    reg_wr(PFS_ADDR_PB_DIR, 8'h00);
    settle();
    chk_reg(pa_oe, 8'hff, "pa output enable");
    chk_reg(pa_out, 8'hff, "pa output level");
    chk_reg({3'h0, pb_out}, 8'h1f, "pb output level");
    reg_wr(PFS_ADDR_PA_DIR, 8'hff);
    reg_wr(PFS_ADDR_PB_DIR, 8'h1f);
  endtask

  task automatic t_out_mux;
    reg_wr(PFS_ADDR_UPPER_PORTA_FUNCTION_SELECT, 8'h15);
    reg_wr(PFS_ADDR_LOWER_PORTB_FUNCTION_SELECT, 8'h02);
    for (int l = 0; l < 2; l++) begin
      @(posedge clk_sys);
      periph <= '{sck_out: 1'b0, sdo_unused: 1'b0, periodic_timer_out: l[0], std_timer_out: l[0], amp0_out: 1'b0, amp1_out: ~l[0]};
      settle();
      chk_pin(pa_out[6], l[0], "pa6 periodic out");
      chk_pin(pa_out[5], ~l[0], "pa5 amp1 out");
      chk_pin(pa_out[4], ~l[0], "pa4 inverted std out");
      chk_pin(pb_out[0], l[0], "pb0 std out");
    end
    reg_wr(PFS_ADDR_UPPER_PORTA_FUNCTION_SELECT, 8'hb2);
    reg_wr(PFS_ADDR_LOWER_PORTB_FUNCTION_SELECT, 8'h03);
    settle();
    chk_reg({4'h0, analog_en[3:0]}, 8'h0f, "analog enables");
    reg_wr(PFS_ADDR_UPPER_PORTA_FUNCTION_SELECT, 8'h40);
    reg_wr(PFS_ADDR_LOWER_PORTB_FUNCTION_SELECT, 8'h20);
    reg_wr(PFS_ADDR_CTRL, 8'h03);
    for (int l = 0; l < 2; l++) begin
      @(posedge clk_sys);
      periph.sck_out <= l[0];
      settle();
      chk_pin(pa_out[0], l[0], "pa0 master clock");
      chk_pin(pa_oe[0], 1'b1, "pa0 master clock enable");
      chk_pin(pa_out[7], l[0], "pa7 serial clock");
      chk_pin(pb_out[2], l[0], "pb2 serial clock");
    end
    reg_wr(PFS_ADDR_CTRL, 8'h00);
  endtask

  task automatic t_in_mux;
    reg_wr(PFS_ADDR_UPPER_PORTA_FUNCTION_SELECT, 8'h60);
    reg_wr(PFS_ADDR_UPPER_PORTB_FUNCTION_SELECT, 8'h01);
    reg_wr(PFS_ADDR_PERIPHERAL_INPUT_SOURCE_SELECT, 8'h19);
    for (int l = 0; l < 2; l++) begin
      // unselected pads sit at the opposite level
      pads(l[0] ? 8'hc0 : 8'h3f, l[0] ? 5'h10 : 5'h0f);
      chk_pin(pin_in.sck_in, l[0], "clock from pa7");
      chk_pin(pin_in.sdi, l[0], "data from pa6");
      chk_pin(pin_in.serial_chip_select, l[0], "select from pb4");
    end
    reg_wr(PFS_ADDR_UPPER_PORTA_FUNCTION_SELECT, 8'hc0);
    reg_wr(PFS_ADDR_PERIPHERAL_INPUT_SOURCE_SELECT, 8'h40);
    for (int l = 0; l < 2; l++) begin
      pads(l[0] ? 8'h80 : 8'h7f, 5'h00);
      chk_pin(pin_in.periodic_timer_capture_in, l[0], "periodic capture from pa7");
      chk_pin(pin_in.std_timer_capture_in, l[0], "std capture from pa7");
    end
    // pb3 left at gpio, so the sdi source pointing at it must stay quiet
    reg_wr(PFS_ADDR_PERIPHERAL_INPUT_SOURCE_SELECT, 8'h26);
    for (int l = 0; l < 2; l++) begin
      pads(l[0] ? 8'h02 : 8'hfd, l[0] ? 5'h0c : 5'h13);
      chk_pin(pin_in.serial_chip_select, l[0], "select from pa1");
      chk_pin(pin_in.sck_in, l[0], "clock from pb2");
      chk_pin(pin_in.sdi, 1'b0, "data from unselected pb3");
      chk_pin(pin_in.std_timer_clock_in, ~l[0], "std clock from pa5");
      chk_pin(pin_in.periodic_timer_clock_in, ~l[0], "periodic clock from pa4");
      chk_pin(pin_in.external_interrupt0, ~l[0], "interrupt from pb0");
    end
  endtask

  task automatic t_rmw;
    pads(8'h5a, 5'h00);
    reg_wr(PFS_ADDR_BITOP, 8'h80);
    reg_chk(PFS_ADDR_PA_DATA, 8'h5b, "data bit set from pins");
    reg_wr(PFS_ADDR_BITOP, 8'h0a);
    reg_chk(PFS_ADDR_PA_DIR, 8'hfb, "direction bit clear");
    reg_wr(PFS_ADDR_BITOP, 8'h8a);
    reg_chk(PFS_ADDR_PA_DIR, 8'hff, "direction bit set");
    reg_wr(PFS_ADDR_PA_DIR, 8'hff);
  endtask

  task automatic count_wake(input int exp, input string msg);
    int n = 0;
    repeat (10) begin
      @(posedge clk_sys);
      #1 n += (wake === 1'b1);
    end
    chk_reg(8'(n), 8'(exp), msg);
  endtask

  task automatic t_wake;
    reg_wr(PFS_ADDR_PA_WAKE, 8'h01);
    reg_wr(PFS_ADDR_CTRL, 8'h04);
    pads(8'hff, 5'h1f);
    @(posedge clk_sys);
    ext_pa <= 8'hfd;
    count_wake(0, "fall on pin without wake");
    @(posedge clk_sys);
    ext_pa <= 8'hfc;
    count_wake(1, "fall on wake pin");
  endtask

  initial begin
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset();
    t_out_high();
    t_out_mux();
    t_in_mux();
    t_rmw();
    t_wake();
    close_out();
  end

  // whole run is about two hundred cycles
  initial begin
    repeat (20000) @(posedge clk_sys);
    fail("watchdog expired");
    close_out();
  end
endmodule // pfs_pin_function_select_mux_test
